// file: rtl/ccr_pkg.sv
// Constants for the control-channel bus configuration and address remap block.
// Assumes one 125 MHz clock and a simple byte-wide register access port.
//
// Notes on behaviour
// - Two-bit code sets SDA delay, 40 ns steps.
// - Lock bit rejects remote writes to local registers.
// - Lock bit never blocks remote access to local targets.
// - Watchdog about 1 s, or 50 us sped up.
// - Watchdog runs only while its disable bit clear.
// - Idle expiry with SDA high marks bus free.
// - Idle expiry with SDA low drives nine SCL pulses.
// - Seven-bit bridge address; zero disables remote access.
// - Link lock loads bridge address unless held.
// - Hold bit keeps software address, ignores autoload.
// - Alias hits rewrite to stored target address.
// - Seven-bit alias; zero disables target access.
// - Second-port select steers per-port field access.
package ccr_pkg;
    // ==========================================================
    // Register offsets.
    localparam logic [7:0] CCR_OFF_CTRL = 8'h05;
    localparam logic [7:0] CCR_OFF_BRIDGE = 8'h06;
    localparam logic [7:0] CCR_OFF_TADDR = 8'h07;
    localparam logic [7:0] CCR_OFF_ALIAS = 8'h08;
    // ==========================================================
    // Field positions of the control register and the bridge hold bit.
    localparam int CCR_BIT_WDDIS = 0;
    localparam int CCR_BIT_SPEED = 1;
    localparam int CCR_BIT_WLOCK = 2;
    localparam int CCR_BIT_DLYLO = 3;
    localparam int CCR_BIT_HOLD = 0;
    localparam logic [7:0] CCR_RST_VAL = 8'h00;
    // ==========================================================
    // Timing figures and cycle counts at 125 MHz.
    localparam longint CCR_CLK_HZ = 125000000;
    localparam longint CCR_WD_LONG_MS = 1000;
    localparam longint CCR_WD_SHORT_US = 50;
    localparam longint CCR_WD_LONG_CYC = CCR_CLK_HZ * CCR_WD_LONG_MS / 1000;
    localparam longint CCR_WD_SHORT_CYC = CCR_CLK_HZ * CCR_WD_SHORT_US / 1000000;
    localparam int CCR_DLY_BASE_NS = 240;
    localparam int CCR_DLY_STEP_NS = 40;
    localparam int CCR_CLK_NS = 8;
    localparam int CCR_DLY_BASE_CYC = CCR_DLY_BASE_NS / CCR_CLK_NS;
    localparam int CCR_DLY_STEP_CYC = CCR_DLY_STEP_NS / CCR_CLK_NS;
    localparam int CCR_REC_PULSES = 9;
    localparam int CCR_REC_HALF_NS = 5000;
    localparam int CCR_REC_HALF_CYC = CCR_REC_HALF_NS / CCR_CLK_NS;
    // ==========================================================
    // Watchdog states.
    typedef enum logic [1:0] {
        CCR_WD_IDLE = 2'b00,
        CCR_WD_RECOVER = 2'b01
    } ccr_wd_t;
endpackage

// file: rtl/ccr_top.sv
// Control-channel bus configuration, watchdog and target address remap.
// Holds the global control byte and two per-port copies of the address fields.
// Assumes unsynchronised SCL/SDA pins and a byte register port on CLK.
// Assumes the recovery drive on SCL is wired as an open-drain pull-down.
`timescale 1ns/1ps
`default_nettype none
module ccr_top
    import ccr_pkg::*;
#(
    parameter longint WD_LONG = CCR_WD_LONG_CYC,
    parameter longint WD_SHORT = CCR_WD_SHORT_CYC,
    parameter int REC_HALF = CCR_REC_HALF_CYC
) (
    // Clock and synchronous active-low reset.
    input wire logic CLK,
    input wire logic RESET_N,
    // Register access port; strobes last one cycle.
    input wire logic REG_WE,
    input wire logic REG_RE,
    input wire logic REG_REMOTE,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic REG_WR_REJECT,
    // Bridge address loader from the control channel.
    input wire logic LINK_LOCK,
    input wire logic LINK_ID_VALID,
    input wire logic LINK_ID_PORT,
    input wire logic [6:0] LINK_ID,
    // Register steering and local transaction remap.
    input wire logic SECOND_PORT_SELECT,
    input wire logic REQ_VALID,
    input wire logic REQ_PORT,
    input wire logic [6:0] REQ_ADDR,
    output logic FWD_VALID,
    output logic FWD_HIT,
    output logic [6:0] FWD_ADDR,
    // Bus pins, recovery drive, bus state and SDA delay setting.
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SCL_O,
    output logic SCL_OE,
    output logic BUS_FREE,
    output logic [1:0] SDA_DLY_CODE,
    output logic [5:0] SDA_DLY_CYC
);
    // ==========================================================
    // Pin synchronisers.
    // The third stage of each chain only serves the edge detector.
    logic scl_m_r; // SCL first stage, may be metastable.
    logic scl_s_r; // SCL settled value.
    logic scl_d_r; // SCL settled value one cycle older.
    logic sda_m_r; // SDA first stage, may be metastable.
    logic sda_s_r; // SDA settled value.
    logic sda_d_r; // SDA settled value one cycle older.

    // Two flip-flops on each bus pin before any logic reads it.
    // Reset loads the idle-high level so no false edge follows reset.
    // Only the second stage feeds the third; nothing else reads the first.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            // Idle-high start values.
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            // Shift each pin one stage along its chain.
            scl_m_r <= SCL_I;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
            sda_m_r <= SDA_I;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
        end
    end

    // ==========================================================
    // Registers.
    // The control byte is shared; the address fields exist once per link port.
    // Register writes and reads see the copy chosen by the second-port select.
    logic [7:0] ctrl_r;                 // Global bus control register.
    logic [6:0] bridge_r [2];           // Remote bridge address per port.
    logic [1:0] hold_r;                 // Address hold bit per port.
    logic [6:0] taddr_r [2];            // Target 0 address per port.
    logic [6:0] alias_r [2];            // Target 0 alias per port.
    logic psel;                         // Port that register access steers to.
    logic wr_ok;                        // Register write accepted.

    // The select is a level from logic on this clock, so it needs no synchroniser.
    assign psel = SECOND_PORT_SELECT;
    // Remote writes are refused while the lock bit is set; target traffic is unaffected.
    assign wr_ok = REG_WE && !(REG_REMOTE && ctrl_r[CCR_BIT_WLOCK]);

    // Control register writes.
    // Bits 7:5 are reserved and always store zero, so they read back as zero.
    // A refused remote write leaves the byte untouched.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ctrl_r <= CCR_RST_VAL;
        end else if (wr_ok && REG_ADDR == CCR_OFF_CTRL) begin
            // Keep only the defined low five bits.
            ctrl_r <= {3'h0, REG_WDATA[4:0]};
        end
    end

    // Per-port registers, one copy per link port.
    // A software write to the bridge address also updates the hold bit beside it.
    // Autoload is taken only while the link reports lock for that port.
    // Port index of the copy built by each loop pass.
    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++) begin : g_port
            // Software writes win; otherwise the link loads the address unless held.
            // A held address survives any number of loads from the link.
            always_ff @(posedge CLK) begin
                if (!RESET_N) begin
                    bridge_r[gp] <= 7'h00;
                    hold_r[gp] <= 1'b0;
                    taddr_r[gp] <= 7'h00;
                    alias_r[gp] <= 7'h00;
                end else if (wr_ok && psel == gp[0]) begin
                    // Address decode of the per-port offsets.
                    if (REG_ADDR == CCR_OFF_BRIDGE) begin
                        bridge_r[gp] <= REG_WDATA[7:1];
                        hold_r[gp] <= REG_WDATA[CCR_BIT_HOLD];
                    end else if (REG_ADDR == CCR_OFF_TADDR) begin
                        taddr_r[gp] <= REG_WDATA[7:1];
                    end else if (REG_ADDR == CCR_OFF_ALIAS) begin
                        alias_r[gp] <= REG_WDATA[7:1];
                    end
                end else if (LINK_LOCK && LINK_ID_VALID && LINK_ID_PORT == gp[0]
                             && !hold_r[gp]) begin
                    bridge_r[gp] <= LINK_ID;
                end
            end
        end
    endgenerate

    // Read data and write reject flag; reserved bits read as zero.
    // Read data holds between reads so a slow master can take it late.
    // The reject flag pulses once for each refused remote write.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            REG_RDATA <= 8'h00;
            REG_WR_REJECT <= 1'b0;
        end else begin
            // A refused write is a strobe that the lock bit turned away.
            REG_WR_REJECT <= REG_WE && !wr_ok;
            if (!REG_RE) begin
                REG_RDATA <= REG_RDATA;
            end else if (REG_ADDR == CCR_OFF_CTRL) begin
                REG_RDATA <= ctrl_r;
            end else if (REG_ADDR == CCR_OFF_BRIDGE) begin
                REG_RDATA <= {bridge_r[psel], hold_r[psel]};
            end else if (REG_ADDR == CCR_OFF_TADDR) begin
                REG_RDATA <= {taddr_r[psel], 1'b0};
            end else if (REG_ADDR == CCR_OFF_ALIAS) begin
                REG_RDATA <= {alias_r[psel], 1'b0};
            end else begin
                // Unmapped offsets read as zero.
                REG_RDATA <= 8'h00;
            end
        end
    end

    // ==========================================================
    // Address remap of local transactions.
    // An alias hit replaces the address by the stored target address.
    // Any other request passes on with its own address unchanged.
    // A zero alias or zero target address can never produce an alias hit.
    logic alias_hit;        // Request matches a nonzero alias.
    logic bridge_hit;       // Request matches a nonzero bridge address.
    // Each request looks at the copy of its own port.
    assign alias_hit = alias_r[REQ_PORT] != 7'h00 && taddr_r[REQ_PORT] != 7'h00
                       && REQ_ADDR == alias_r[REQ_PORT];
    // Requests for the bridge itself are forwarded when its address is set.
    assign bridge_hit = bridge_r[REQ_PORT] != 7'h00
                        && REQ_ADDR == bridge_r[REQ_PORT];

    // Forward decision one cycle after each request.
    // The address output follows every cycle; it only matters with the valid pulse.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            FWD_VALID <= 1'b0;
            FWD_HIT <= 1'b0;
            FWD_ADDR <= 7'h00;
        end else begin
            // Register the decision so every output comes from a flip-flop.
            FWD_VALID <= REQ_VALID;
            FWD_HIT <= REQ_VALID && (alias_hit || bridge_hit);
            FWD_ADDR <= alias_hit ? taddr_r[REQ_PORT] : REQ_ADDR;
        end
    end

    // ==========================================================
    // SDA output delay.
    // Delay in cycles: 240 ns base plus 40 ns per code step.
    // The code and the cycle count are published for the SDA output stage.
    // At 8 ns per cycle the four codes give 30, 35, 40 and 45 cycles.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            SDA_DLY_CODE <= 2'b00;
            SDA_DLY_CYC <= 6'(CCR_DLY_BASE_CYC);
        end else begin
            // Both outputs follow the control byte one cycle late.
            SDA_DLY_CODE <= ctrl_r[CCR_BIT_DLYLO +: 2];
            SDA_DLY_CYC <= 6'(CCR_DLY_BASE_CYC)
                           + 6'(CCR_DLY_STEP_CYC) * {4'h0, ctrl_r[CCR_BIT_DLYLO +: 2]};
        end
    end

    // ==========================================================
    // Bus watchdog and recovery.
    // The idle counter runs only while the watchdog is enabled and idle.
    // On expiry a high SDA means the bus is free; a low SDA starts recovery.
    // Recovery drives nine low and high SCL pulses, then releases the pin.
    ccr_wd_t wd_st_r;
    logic [27:0] wd_cnt_r;          // Idle cycle count.
    logic [27:0] wd_lim;            // Selected expiry count.
    logic [15:0] half_r;            // Recovery half-period timer.
    logic [4:0] edges_r;            // Recovery SCL edges remaining.
    logic bus_act;                  // Any edge on SCL or SDA.
    logic wd_exp;                   // Idle count has reached the selected limit less one.

    // Activity is any change between the settled and older pin values.
    assign bus_act = (scl_s_r != scl_d_r) || (sda_s_r != sda_d_r);
    // The speedup bit picks the short limit.
    assign wd_lim = ctrl_r[CCR_BIT_SPEED] ? 28'(WD_SHORT) : 28'(WD_LONG);
    // Expiry falls on the cycle the count reaches the limit less one.
    assign wd_exp = wd_cnt_r >= wd_lim - 28'h1;

    // Idle counter restarts on activity and is held off when disabled.
    // It also restarts on expiry, so a free bus is announced again later.
    // During recovery the driven SCL edges would restart it anyway.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            wd_cnt_r <= 28'h0;
        end else if (ctrl_r[CCR_BIT_WDDIS] || bus_act || wd_st_r != CCR_WD_IDLE
                     || wd_exp) begin
            wd_cnt_r <= 28'h0;
        end else begin
            // Quiet cycle: count one more.
            wd_cnt_r <= wd_cnt_r + 28'h1;
        end
    end

    // Expiry either declares the bus free or clocks out nine recovery pulses.
    // Each half period lasts REC_HALF plus one cycles.
    // The first low half starts on entry, so seventeen toggles give nine pulses.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            wd_st_r <= CCR_WD_IDLE;
            half_r <= 16'h0;
            edges_r <= 5'h0;
            SCL_O <= 1'b1;
            SCL_OE <= 1'b0;
            BUS_FREE <= 1'b0;
        end else begin
            case (wd_st_r)
                CCR_WD_IDLE: begin
                    SCL_OE <= 1'b0;
                    SCL_O <= 1'b1;
                    // Any pin edge means the bus is in use again.
                    if (bus_act) begin
                        BUS_FREE <= 1'b0;
                    end else if (wd_exp && !ctrl_r[CCR_BIT_WDDIS]) begin
                        // A released SDA means no target is stuck.
                        if (sda_s_r) begin
                            BUS_FREE <= 1'b1;
                        end else begin
                            wd_st_r <= CCR_WD_RECOVER;
                            edges_r <= 5'(2 * CCR_REC_PULSES);
                            half_r <= 16'(REC_HALF);
                            SCL_OE <= 1'b1;
                            SCL_O <= 1'b0;
                        end
                    end
                end
                CCR_WD_RECOVER: begin
                    // Count down the current half period first.
                    if (half_r != 16'h0) begin
                        half_r <= half_r - 16'h1;
                    end else if (edges_r == 5'h1) begin
                        // Last half done: release SCL and return to idle.
                        SCL_OE <= 1'b0;
                        SCL_O <= 1'b1;
                        edges_r <= 5'h0;
                        wd_st_r <= CCR_WD_IDLE;
                    end else begin
                        // Toggle SCL and start the next half period.
                        SCL_O <= ~SCL_O;
                        half_r <= 16'(REC_HALF);
                        edges_r <= edges_r - 5'h1;
                    end
                end
                default: begin
                    // Unused code: return to idle.
                    wd_st_r <= CCR_WD_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: sim/ccr_top_sva.sv
// Checker for ccr_top: relations between its ports.
// Assumes one clock domain and REC_HALF handed down by the bind.
`timescale 1ns/1ps
`default_nettype none
module ccr_top_sva #(
    parameter int REC_HALF = 3
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic REG_WE,
    input wire logic REG_RE,
    input wire logic REG_REMOTE,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_WR_REJECT,
    input wire logic REQ_VALID,
    input wire logic FWD_VALID,
    input wire logic FWD_HIT,
    input wire logic SCL_I,
    input wire logic SDA_I,
    input wire logic SCL_O,
    input wire logic SCL_OE,
    input wire logic BUS_FREE,
    input wire logic [1:0] SDA_DLY_CODE,
    input wire logic [5:0] SDA_DLY_CYC
);
    // ==========================================================
    // Properties.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    property p_dly; SDA_DLY_CYC == 6'd30 + 6'(5 * SDA_DLY_CODE); endproperty
    property p_rej; REG_WR_REJECT |-> $past(REG_WE) && $past(REG_REMOTE); endproperty
    property p_rd; !$past(REG_RE) |-> $stable(REG_RDATA); endproperty
    property p_fwd; FWD_VALID == $past(REQ_VALID); endproperty
    property p_hit; FWD_HIT |-> FWD_VALID; endproperty
    property p_rec; $rose(SCL_OE) |-> !SCL_O && !BUS_FREE; endproperty
    property p_half;
        SCL_OE && $changed(SCL_O) |=> ##REC_HALF ($changed(SCL_O) || !SCL_OE);
    endproperty
    property p_free; BUS_FREE && $changed(SDA_I) |-> ##[1:4] !BUS_FREE; endproperty
    property p_idle; $changed(SDA_I) || $changed(SCL_I) |=> (!$rose(BUS_FREE)) [*8]; endproperty
    a_dly: assert property (p_dly) else $error("sda delay mismatch");
    a_rej: assert property (p_rej) else $error("stray reject");
    a_rd: assert property (p_rd) else $error("read data moved");
    a_fwd: assert property (p_fwd) else $error("forward timing");
    a_hit: assert property (p_hit) else $error("hit without valid");
    a_rec: assert property (p_rec) else $error("bad recovery start");
    a_half: assert property (p_half) else $error("bad scl half period");
    a_free: assert property (p_free) else $error("free not cleared");
    a_idle: assert property (p_idle) else $error("free right after edge");
    c_free: cover property ($rose(BUS_FREE));
    c_rec: cover property ($rose(SCL_OE));
    c_hit: cover property (FWD_HIT);
    c_rej: cover property (REG_WR_REJECT);
endmodule
bind ccr_top ccr_top_sva #(.REC_HALF(REC_HALF)) u_sva (.CLK(CLK), .RESET_N(RESET_N),
    .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_REMOTE(REG_REMOTE), .REG_RDATA(REG_RDATA),
    .REG_WR_REJECT(REG_WR_REJECT), .REQ_VALID(REQ_VALID), .FWD_VALID(FWD_VALID),
    .FWD_HIT(FWD_HIT), .SCL_I(SCL_I), .SDA_I(SDA_I), .SCL_O(SCL_O), .SCL_OE(SCL_OE),
    .BUS_FREE(BUS_FREE), .SDA_DLY_CODE(SDA_DLY_CODE), .SDA_DLY_CYC(SDA_DLY_CYC));
`default_nettype wire

// file: sim/ccr_far_model.sv
// Far side: pulled-up bus pins and the link's address loader.
// Assumes tasks are called from the bench between clock edges.
`timescale 1ns/1ps
`default_nettype none
module ccr_far_model (
    input wire logic CLK,
    input wire logic SCL_O,
    input wire logic SCL_OE,
    output logic SCL_I,
    output logic SDA_I,
    output logic LINK_LOCK,
    output logic LINK_ID_VALID,
    output logic LINK_ID_PORT,
    output logic [6:0] LINK_ID
);
    logic sda_low_r = 1'b0; // Held low by a stuck target when set.
    // Open drain with pull-ups: low only while someone pulls.
    assign SCL_I = !(SCL_OE && !SCL_O);
    assign SDA_I = !sda_low_r;
    initial begin
        {LINK_LOCK, LINK_ID_VALID, LINK_ID_PORT, LINK_ID} = '0;
    end
    // Set the lock level and send one address; the id lines then go stale.
    task automatic send_id(input logic port, input logic [6:0] id, input logic lk);
        @(negedge CLK);
        {LINK_LOCK, LINK_ID_VALID, LINK_ID_PORT, LINK_ID} = {lk, 1'b1, port, id};
        @(negedge CLK);
        LINK_ID_VALID = 1'b0;
        LINK_ID = ~id;
    endtask
    task automatic set_sda(input logic v);
        @(negedge CLK);
        sda_low_r = !v;
    endtask
endmodule
`default_nettype wire

// file: sim/test_ccr_top.sv
// Self-checking bench for ccr_top with short watchdog counts.
// Assumes ccr_pkg, the checker and the far model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_ccr_top;
    import ccr_pkg::*;
    logic clk, reset_n, we, re, remote, sps, rq_v, rq_p, rej, lock, idv, idp, fv, fh;
    logic scl_i, sda_i, scl_o, scl_oe, free;
    logic [7:0] addr, wdata, rdata;
    logic [6:0] rq_a, fa, lid;
    logic [1:0] code;
    logic [5:0] cyc;
    int miscompares = 0;
    int checks = 0;
    int n;
    ccr_top #(.WD_LONG(200), .WD_SHORT(50), .REC_HALF(3)) u_dut (.CLK(clk), .RESET_N(reset_n),
        .REG_WE(we), .REG_RE(re), .REG_REMOTE(remote), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .REG_WR_REJECT(rej), .LINK_LOCK(lock), .LINK_ID_VALID(idv),
        .LINK_ID_PORT(idp), .LINK_ID(lid), .SECOND_PORT_SELECT(sps), .REQ_VALID(rq_v),
        .REQ_PORT(rq_p), .REQ_ADDR(rq_a), .FWD_VALID(fv), .FWD_HIT(fh), .FWD_ADDR(fa),
        .SCL_I(scl_i), .SDA_I(sda_i), .SCL_O(scl_o), .SCL_OE(scl_oe), .BUS_FREE(free),
        .SDA_DLY_CODE(code), .SDA_DLY_CYC(cyc));
    ccr_far_model u_far (.CLK(clk), .SCL_O(scl_o), .SCL_OE(scl_oe), .SCL_I(scl_i),
        .SDA_I(sda_i), .LINK_LOCK(lock), .LINK_ID_VALID(idv), .LINK_ID_PORT(idp), .LINK_ID(lid));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Register write at the falling edge; the reject flag is taken one cycle on.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic rm, input logic xr);
        @(negedge clk);
        {addr, wdata, remote, we} = {a, d, rm, 1'b1};
        @(negedge clk);
        {remote, we} = 2'b00;
        chk("reject", {7'h00, rej}, {7'h00, xr});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(negedge clk);
        {addr, re} = {a, 1'b1};
        @(negedge clk);
        re = 1'b0;
        chk("rdata", rdata, x);
    endtask
    task automatic req(input logic p, input logic [6:0] a, input logic xh, input logic [6:0] xa);
        @(negedge clk);
        {rq_v, rq_p, rq_a} = {1'b1, p, a};
        @(negedge clk);
        rq_v = 1'b0;
        chk("fwd", {6'h00, fv, fh}, {6'h00, 1'b1, xh});
        if (xh) chk("fwd_addr", {1'b0, fa}, {1'b0, xa});
    endtask
    // Second-port select, changed at a falling edge.
    task automatic sel(input logic p);
        @(negedge clk);
        sps = p;
    endtask
    task automatic t_basic();
        for (int a = 5; a < 10; a++) rd(8'(a), 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(CCR_OFF_CTRL, 8'(c << 3), 1'b0, 1'b0);
            // The delay outputs settle one cycle after the write, so read first.
            rd(CCR_OFF_CTRL, 8'(c << 3));
            chk("dly", {code, cyc}, {2'(c), 6'(30 + 5 * c)});
        end
        $display("t_basic done");
    endtask
    task automatic t_lock_remap();
        wr(CCR_OFF_CTRL, 8'h04, 1'b0, 1'b0);
        wr(CCR_OFF_TADDR, 8'hA1, 1'b0, 1'b0);
        wr(CCR_OFF_ALIAS, 8'h78, 1'b0, 1'b0);
        wr(CCR_OFF_BRIDGE, 8'hA4, 1'b1, 1'b1);
        rd(CCR_OFF_BRIDGE, 8'h00);
        rd(CCR_OFF_TADDR, 8'hA0);
        req(1'b0, 7'h3C, 1'b1, 7'h50);
        req(1'b0, 7'h3D, 1'b0, 7'h00);
        wr(CCR_OFF_CTRL, 8'h00, 1'b0, 1'b0);
        wr(CCR_OFF_BRIDGE, 8'h22, 1'b1, 1'b0);
        rd(CCR_OFF_BRIDGE, 8'h22);
        req(1'b1, 7'h3C, 1'b0, 7'h00);
        sel(1'b1);
        wr(CCR_OFF_ALIAS, 8'h78, 1'b0, 1'b0);
        wr(CCR_OFF_TADDR, 8'h40, 1'b0, 1'b0);
        req(1'b1, 7'h3C, 1'b1, 7'h20);
        sel(1'b0);
        wr(CCR_OFF_TADDR, 8'h00, 1'b0, 1'b0);
        req(1'b0, 7'h3C, 1'b0, 7'h00);
        $display("t_lock_remap done");
    endtask
    task automatic t_autoload();
        u_far.send_id(1'b0, 7'h2A, 1'b1);
        rd(CCR_OFF_BRIDGE, 8'h54);
        wr(CCR_OFF_BRIDGE, 8'h23, 1'b0, 1'b0);
        u_far.send_id(1'b0, 7'h33, 1'b1);
        rd(CCR_OFF_BRIDGE, 8'h23);
        u_far.send_id(1'b1, 7'h15, 1'b1);
        sel(1'b1);
        rd(CCR_OFF_BRIDGE, 8'h2A);
        // Without lock the link's address is ignored.
        u_far.send_id(1'b1, 7'h0C, 1'b0);
        rd(CCR_OFF_BRIDGE, 8'h2A);
        sel(1'b0);
        $display("t_autoload done");
    endtask
    // Idle span and restart of the watchdog, counted in falling edges.
    task automatic idle(input int lim);
        u_far.set_sda(1'b0);
        u_far.set_sda(1'b1);
        // Let the edges clear any earlier free state before counting.
        repeat (2) @(negedge clk);
        for (n = 0; free !== 1'b1 && n < lim; n++) @(negedge clk);
    endtask
    task automatic t_watchdog();
        wr(CCR_OFF_CTRL, 8'h02, 1'b0, 1'b0);
        idle(120);
        chk("short", 8'(n >= 45 && n <= 60), 8'h01);
        u_far.set_sda(1'b0);
        repeat (6) @(negedge clk);
        chk("free_drop", {7'h00, free}, 8'h00);
        for (n = 0; scl_oe !== 1'b1 && n < 100; n++) @(negedge clk);
        for (n = 0; scl_oe === 1'b1; ) begin
            @(posedge scl_o or negedge scl_oe);
            if (scl_oe === 1'b1) n++;
        end
        u_far.set_sda(1'b1);
        chk("pulses", 8'(n), 8'd9);
        wr(CCR_OFF_CTRL, 8'h03, 1'b0, 1'b0);
        idle(150);
        chk("disabled", {7'h00, free}, 8'h00);
        wr(CCR_OFF_CTRL, 8'h00, 1'b0, 1'b0);
        idle(300);
        chk("long", 8'(n >= 190 && n <= 215), 8'h01);
        $display("t_watchdog done");
    endtask
    task automatic close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        {reset_n, we, re, remote, sps, rq_v, rq_p, rq_a, addr, wdata} = '0;
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        t_basic();
        t_lock_remap();
        t_autoload();
        t_watchdog();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("Watchdog limit reached");
        close_out();
    end
endmodule
`default_nettype wire
